// ===== pafd_pkg.sv
// Constants, field layouts and types shared by the picture adjustment block.
// Assumes a single 100 MHz core clock and an active-high asynchronous reset.
//
// Overview of operation
// R1 - Contrast setting, reset 0x80, scales output luma.
// R2 - Saturation gain on colour: 0x00 weakest, 0x80 unity, 0xFF strongest.
// R3 - Signed brightness offset added to luma, zero at code 0x00.
// R4 - Signed hue setting rotates chroma, 0x7F near +90 and 0x80 at -90 degrees.
// R5 - Force-fill bit replaces decoded video with the fill values.
// R6 - Auto-fill bit replaces video with fill values while lock is lost.
// R7 - Six-bit luma fill value in bits 7 to 2, reset 000100.
// R8 - Cr fill is upper nibble then zeros, Cb lower nibble then zeros; reset 0x88.
// R9 - Field dropping only while its enable bit is set; otherwise all fields pass.
// R10 - Two-bit pattern picks frame or field dropping and starting parity.
// R11 - Skip count fields or frames, pass one, then repeat.
// R12 - Count on field parity changes; restart on enable or setting change.
package pafd_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register indices; the byte address is four times the index.
	localparam logic [5:0] PAFD_IDX_PICTURE_GAIN = 6'h08;
	localparam logic [5:0] PAFD_IDX_CHROMA_GAIN = 6'h09;
	localparam logic [5:0] PAFD_IDX_LUMA_OFFSET = 6'h0a;
	localparam logic [5:0] PAFD_IDX_HUE_ROTATION = 6'h0b;
	localparam logic [5:0] PAFD_IDX_LUMA_FILL = 6'h0c;
	localparam logic [5:0] PAFD_IDX_CHROMA_FILL = 6'h0d;
	localparam logic [5:0] PAFD_IDX_FIELD_DROP = 6'h0e;
	localparam logic [5:0] PAFD_IDX_STATUS = 6'h12;

	////////////////////////////////////////////////////////////////////////////
	// Values after reset.
	localparam logic [7:0] PAFD_RST_PICTURE_GAIN = 8'h80;
	localparam logic [7:0] PAFD_RST_CHROMA_GAIN = 8'h80;
	localparam logic [7:0] PAFD_RST_LUMA_OFFSET = 8'h00;
	localparam logic [7:0] PAFD_RST_HUE_ROTATION = 8'h00;
	localparam logic [7:0] PAFD_RST_LUMA_FILL = 8'h10;
	localparam logic [7:0] PAFD_RST_CHROMA_FILL = 8'h88;
	localparam logic [6:0] PAFD_RST_FIELD_DROP = 7'h00;

	////////////////////////////////////////////////////////////////////////////
	// Field positions.
	localparam int PAFD_FORCE_FILL_BIT = 0;
	localparam int PAFD_AUTO_FILL_BIT = 1;
	localparam int PAFD_LUMA_FILL_LSB = 2;

	////////////////////////////////////////////////////////////////////////////
	// Buffer shape.
	localparam int PAFD_FIFO_WIDTH = 24;
	localparam int PAFD_FIFO_DEPTH = 16;

	////////////////////////////////////////////////////////////////////////////
	// Types.
	typedef struct packed {
		logic [7:0] y;
		logic [7:0] cb;
		logic [7:0] cr;
	} pafd_pixel_t;

	typedef enum logic [1:0] {
		DROP_FRAME_EVEN = 2'h0,
		DROP_FRAME_ODD = 2'h1,
		DROP_EVEN_FIELDS = 2'h2,
		DROP_ODD_FIELDS = 2'h3
	} pafd_pattern_t;

	typedef struct packed {
		logic [3:0] fieldDropCount;
		pafd_pattern_t fieldDropPattern;
		logic fieldDropEnable;
	} pafd_drop_cfg_t;

	typedef enum logic [1:0] {
		DEC_OFF = 2'h0,
		DEC_PASS = 2'h1,
		DEC_DROP = 2'h3
	} pafd_dec_state_t;

endpackage : pafd_pkg

// ===== pafd_top.sv
// Picture adjustment, fill substitution and field dropping on a pixel stream,
// with a classic Wishbone register slave and an output buffer.
// Assumes all inputs are synchronous to clk and fieldOdd changes only at fields.

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO with a registered output stage.
module pafd_fifo
	import pafd_pkg::*;
#(
	parameter int WIDTH = PAFD_FIFO_WIDTH,
	parameter int DEPTH = PAFD_FIFO_DEPTH
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Fill side
	input wire logic wrValid,
	output logic wrReady,
	input wire logic [WIDTH-1:0] wrData,
	// Drain side
	output logic rdValid,
	input wire logic rdReady,
	output logic [WIDTH-1:0] rdData
);
	// DEPTH words sit in memory and one more in the output register, so the fill
	// side can run one word further ahead of a stalled drain.
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr;
	logic [AW-1:0] rdPtr;
	logic [AW:0] count;

	// Ready is kept in a flop of its own, so the port needs no gate behind it.
	wire logic full = !wrReady;
	wire logic push = wrValid && !full;
	wire logic empty = (count == '0);
	wire logic pop = !empty && (!rdValid || rdReady);
	wire logic [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

	// The storage has no reset; the count guards every pop, so stale words are
	// never read.
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wrPtr] <= wrData;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wrPtr <= '0;
			rdPtr <= '0;
			count <= '0;
			wrReady <= 1'b1;
		end
		else
		begin
			if (push)
				wrPtr <= wrPtr + 1'b1;
			if (pop)
				rdPtr <= rdPtr + 1'b1;
			count <= next_count;
			wrReady <= (next_count != (AW+1)'(DEPTH));
		end
	end

	// A pop refills the output register; without one it empties once the drain takes it.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rdValid <= 1'b0;
			rdData <= '0;
		end
		else if (pop)
		begin
			rdValid <= 1'b1;
			rdData <= mem[rdPtr];
		end
		else if (rdReady)
			rdValid <= 1'b0;
	end

endmodule : pafd_fifo

////////////////////////////////////////////////////////////////////////////////
// Top level.
module pafd_top
	import pafd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Decoded pixel input
	input wire logic inValid,
	output logic inReady,
	input wire pafd_pixel_t inPixel,
	input wire logic fieldOdd,
	input wire logic lineLocked,
	// Adjusted pixel output
	output logic outValid,
	input wire logic outReady,
	output pafd_pixel_t outPixel
);

	////////////////////////////////////////////////////////////////////////////
	// Arithmetic helpers.
	// Limits a signed luma sum to the eight-bit output range.
	function automatic logic [7:0] clampLuma(input logic signed [17:0] v);
		if (v < 18'sd0)
			return 8'h00;
		else if (v > 18'sd255)
			return 8'hff;
		else
			return v[7:0];
	endfunction : clampLuma

	// Scales a rotated chroma term by the saturation gain and recentres it.
	function automatic logic [7:0] chromaOut(input logic signed [19:0] rot,
		input logic [7:0] gain);
		logic signed [28:0] prod;
		logic signed [21:0] sc;
		logic signed [7:0] c;
		prod = (rot >>> 7) * $signed({1'b0, gain});
		sc = $signed(prod[28:7]);
		if (sc > 22'sd127)
			c = 8'sh7f;
		else if (sc < -22'sd128)
			c = 8'sh80;
		else
			c = sc[7:0];
		return {~c[7], c[6:0]};
	endfunction : chromaOut

	////////////////////////////////////////////////////////////////////////////
	// Registers.
	logic [7:0] pictureGainLevel;
	logic [7:0] chromaGainLevel;
	logic [7:0] lumaOffsetLevel;
	logic [7:0] hueRotation;
	logic [7:0] lumaFillReg;
	logic [7:0] chromaFillPair;
	pafd_drop_cfg_t dropCfg;
	logic [31:0] readMux;

	pafd_dec_state_t decState;
	pafd_dec_state_t next_decState;
	logic [3:0] skipCount;
	logic [3:0] next_skipCount;
	// Parity seen in the previous cycle; a difference marks a field start.
	logic prevOdd;
	pafd_drop_cfg_t lastCfg;

	////////////////////////////////////////////////////////////////////////////
	// Wishbone decode.
	// Every taken request is answered one cycle later, whatever the address.
	// Unmapped indices read as zero and ignore writes.
	// A request is taken only while ack is low, so the cycle that carries ack
	// never takes a second request.
	wire logic wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire logic wbWrite = wbReq && wb_we_i && wb_sel_i[0];
	wire logic [5:0] regIdx = wb_adr_i[7:2];
	// Fill is live when forced, or when auto fill is on and line lock is lost.
	wire logic fillActive = lumaFillReg[PAFD_FORCE_FILL_BIT] ||
		(lumaFillReg[PAFD_AUTO_FILL_BIT] && !lineLocked);  // [R5] [R6]

	always_comb
	begin
		readMux = 32'h0000_0000;
		if (regIdx == PAFD_IDX_PICTURE_GAIN)
			readMux[7:0] = pictureGainLevel;
		else if (regIdx == PAFD_IDX_CHROMA_GAIN)
			readMux[7:0] = chromaGainLevel;
		else if (regIdx == PAFD_IDX_LUMA_OFFSET)
			readMux[7:0] = lumaOffsetLevel;
		else if (regIdx == PAFD_IDX_HUE_ROTATION)
			readMux[7:0] = hueRotation;
		else if (regIdx == PAFD_IDX_LUMA_FILL)
			readMux[7:0] = lumaFillReg;
		else if (regIdx == PAFD_IDX_CHROMA_FILL)
			readMux[7:0] = chromaFillPair;
		else if (regIdx == PAFD_IDX_FIELD_DROP)
			readMux[7:0] = {1'b0, dropCfg};
		// Status is read only and shows the live fill and dropping state.
		else if (regIdx == PAFD_IDX_STATUS)
			readMux[7:0] = {skipCount, fieldOdd, lineLocked,
				decState == DEC_DROP, fillActive};
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wbReq;
			if (wbReq)
				wb_dat_o <= readMux;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			pictureGainLevel <= PAFD_RST_PICTURE_GAIN;  // [R1]
			chromaGainLevel <= PAFD_RST_CHROMA_GAIN;
			lumaOffsetLevel <= PAFD_RST_LUMA_OFFSET;
			hueRotation <= PAFD_RST_HUE_ROTATION;
			lumaFillReg <= PAFD_RST_LUMA_FILL;  // [R7]
			chromaFillPair <= PAFD_RST_CHROMA_FILL;  // [R8]
			dropCfg <= PAFD_RST_FIELD_DROP;
		end
		// Only byte lane 0 holds a register; the other lanes are ignored.
		else if (wbWrite)
		begin
			if (regIdx == PAFD_IDX_PICTURE_GAIN)
				pictureGainLevel <= wb_dat_i[7:0];
			else if (regIdx == PAFD_IDX_CHROMA_GAIN)
				chromaGainLevel <= wb_dat_i[7:0];
			else if (regIdx == PAFD_IDX_LUMA_OFFSET)
				lumaOffsetLevel <= wb_dat_i[7:0];
			else if (regIdx == PAFD_IDX_HUE_ROTATION)
				hueRotation <= wb_dat_i[7:0];
			else if (regIdx == PAFD_IDX_LUMA_FILL)
				lumaFillReg <= wb_dat_i[7:0];
			else if (regIdx == PAFD_IDX_CHROMA_FILL)
				chromaFillPair <= wb_dat_i[7:0];
			else if (regIdx == PAFD_IDX_FIELD_DROP)
				dropCfg <= wb_dat_i[6:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Luma path: contrast gain then signed brightness offset.
	// Unity gain is 0x80, so the product drops seven bits; the sum stays wide and
	// signed so that the clamp sees both underflow and overflow.
	wire logic [15:0] lumaProd = inPixel.y * pictureGainLevel;  // [R1]
	wire logic signed [17:0] lumaSum = $signed({9'h000, lumaProd[15:7]}) +
		18'($signed(lumaOffsetLevel));  // [R3]

	////////////////////////////////////////////////////////////////////////////
	// Chroma path: hue rotation with a parabolic sine, then saturation gain.
	// The parabolic sine and cosine trade a little angular accuracy for having no
	// lookup table; both are exact at a hue of zero and at 0x80.
	wire logic [7:0] hueMag = hueRotation[7] ? (8'h00 - hueRotation) : hueRotation;
	wire logic [16:0] sinProd = hueMag * (9'h100 - {1'b0, hueMag});
	wire logic [15:0] hueSq = hueMag * hueMag;
	wire logic [16:0] cosProd = 17'h04000 - {1'b0, hueSq};
	wire logic signed [9:0] sinPos = $signed({1'b0, sinProd[15:7]});
	wire logic signed [9:0] sinS = hueRotation[7] ? -sinPos : sinPos;  // [R4]
	wire logic signed [9:0] cosS = $signed({1'b0, cosProd[15:7]});
	wire logic signed [8:0] cbC = $signed({1'b0, inPixel.cb}) - 9'sd128;
	wire logic signed [8:0] crC = $signed({1'b0, inPixel.cr}) - 9'sd128;
	wire logic signed [19:0] cbRot = cbC * cosS - crC * sinS;  // [R4]
	wire logic signed [19:0] crRot = crC * cosS + cbC * sinS;  // [R4]

	////////////////////////////////////////////////////////////////////////////
	// Output selection between adjusted video and the fill values.
	pafd_pixel_t adjPixel;
	pafd_pixel_t fillPixel;
	pafd_pixel_t selPixel;

	assign adjPixel.y = clampLuma(lumaSum);
	assign adjPixel.cb = chromaOut(cbRot, chromaGainLevel);  // [R2]
	assign adjPixel.cr = chromaOut(crRot, chromaGainLevel);  // [R2]
	assign fillPixel.y = {lumaFillReg[7:PAFD_LUMA_FILL_LSB], 2'b00};  // [R7]
	assign fillPixel.cr = {chromaFillPair[7:4], 4'h0};  // [R8]
	assign fillPixel.cb = {chromaFillPair[3:0], 4'h0};  // [R8]
	assign selPixel = fillActive ? fillPixel : adjPixel;  // [R5] [R6]

	////////////////////////////////////////////////////////////////////////////
	// Field dropping.
	// Any change of the drop setting restarts the count, so a new rate never
	// inherits a skip that was counted under the old one.
	wire logic fieldStart = (fieldOdd != prevOdd);  // [R12]
	wire logic cfgChange = (dropCfg != lastCfg);  // [R12]
	wire logic isTarget = dropCfg.fieldDropPattern[0] ? fieldOdd : !fieldOdd;  // [R10]
	wire logic fieldMode = dropCfg.fieldDropPattern[1];  // [R10]

	always_comb
	begin
		next_decState = decState;
		next_skipCount = skipCount;
		if (!dropCfg.fieldDropEnable)
		begin
			next_decState = DEC_OFF;  // [R9]
			next_skipCount = 4'h0;
		end
		else if (cfgChange)
		begin
			next_decState = DEC_PASS;  // [R12]
			next_skipCount = 4'h0;
		end
		else if (fieldStart)
		begin
			case (isTarget)
				1'b1:
				begin
					if (skipCount < dropCfg.fieldDropCount)
					begin
						next_decState = DEC_DROP;  // [R11]
						next_skipCount = skipCount + 4'h1;
					end
					else
					begin
						next_decState = DEC_PASS;  // [R11]
						next_skipCount = 4'h0;
					end
				end
				default:
				begin
					// Field modes always pass the other parity; frame modes keep the
					// decision of the field that opened the frame.
					if (fieldMode)
						next_decState = DEC_PASS;  // [R10]
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			decState <= DEC_OFF;
			skipCount <= 4'h0;
			prevOdd <= 1'b0;
			lastCfg <= PAFD_RST_FIELD_DROP;
		end
		else
		begin
			decState <= next_decState;
			skipCount <= next_skipCount;
			prevOdd <= fieldOdd;
			lastCfg <= dropCfg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output buffer; dropped pixels are accepted and discarded.
	// The decision of a field start already applies to the pixel of that cycle,
	// and a dropped pixel still waits for ready like any other.
	wire logic dropNow = (next_decState == DEC_DROP);  // [R9] [R11]
	wire logic bufWrValid = inValid && !dropNow;

	pafd_fifo #(
		.WIDTH(PAFD_FIFO_WIDTH),
		.DEPTH(PAFD_FIFO_DEPTH)
	) outBuf (
		.clk(clk),
		.rst(rst),
		.wrValid(bufWrValid),
		.wrReady(inReady),
		.wrData(selPixel),
		.rdValid(outValid),
		.rdReady(outReady),
		.rdData(outPixel)
	);

endmodule : pafd_top

// ===== pafd_properties.sv
// Checker for the bus handshake, output hold and fill substitution.
// Sees only the ports of pafd_top and is bound to it below.
module pafd_properties
	import pafd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Stream
	input wire logic inValid,
	input wire logic inReady,
	input wire logic lineLocked,
	input wire logic outValid,
	input wire logic outReady,
	input wire pafd_pixel_t outPixel
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [7:0] lumaFill;
	logic [7:0] chromaFill;
	wire logic wrTake = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
	wire logic fillOn = lumaFill[0] || (lumaFill[1] && !lineLocked);
	wire logic [7:0] fillY = {lumaFill[7:2], 2'b00};
	wire logic [15:0] fillC = {chromaFill[3:0], 4'h0, chromaFill[7:4], 4'h0};
	always_ff @(posedge clk or posedge rst)
		if (rst)
			lumaFill <= 8'h10;
		else if (wrTake && wb_adr_i == 8'h30)
			lumaFill <= wb_dat_i[7:0];
	always_ff @(posedge clk or posedge rst)
		if (rst)
			chromaFill <= 8'h88;
		else if (wrTake && wb_adr_i == 8'h34)
			chromaFill <= wb_dat_i[7:0];
	////////////////////////////////////////////////////////////////////////////
	property p_ack_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_take: assert property (p_ack_take) else $error("no ack after request");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_ack_cause;
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_read_width;
		wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0;
	endproperty
	a_read_width: assert property (p_read_width) else $error("read data upper bits set");
	property p_out_hold;
		outValid && !outReady |=> outValid && $stable(outPixel);
	endproperty
	a_out_hold: assert property (p_out_hold) else $error("output changed while stalled");
	property p_out_cause;
		$rose(outValid) |-> $past(inValid && inReady, 2);
	endproperty
	a_out_cause: assert property (p_out_cause) else $error("output without input");
	property p_fill_luma;
		$rose(outValid) && $past(fillOn, 2) |-> outPixel.y == $past(fillY, 2);
	endproperty
	a_fill_luma: assert property (p_fill_luma) else $error("luma fill wrong");
	property p_fill_chroma;
		$rose(outValid) && $past(fillOn, 2) |-> {outPixel.cb, outPixel.cr} == $past(fillC, 2);
	endproperty
	a_fill_chroma: assert property (p_fill_chroma) else $error("chroma fill wrong");
endmodule : pafd_properties

bind pafd_top pafd_properties uChk (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .inValid, .inReady, .lineLocked, .outValid,
	.outReady, .outPixel);

// ===== pafd_sink.sv
// Downstream consumer of the adjusted pixel stream, collecting what it takes.
// Assumes mode 0 always ready, 1 random stalls, 2 never ready.
module pafd_sink
	import pafd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Stream
	input wire logic outValid,
	output logic outReady,
	input wire pafd_pixel_t outPixel,
	// Bench control
	input wire logic [1:0] mode
);
	timeunit 1ns;
	timeprecision 1ps;
	int seed = 43422;
	pafd_pixel_t got[$];
	always @(posedge clk or posedge rst)
		if (rst)
			outReady <= 1'b0;
		else
		begin
			if (outValid && outReady)
				got.push_back(outPixel);
			outReady <= mode == 2'h0 || (mode == 2'h1 && $random(seed) % 2 == 0);
		end
endmodule : pafd_sink

// ===== picture_adjust_field_decimation_tb_top.sv
// Self-checking bench: registers, adjustment, fill, buffer and field dropping.
// Assumes pafd_top, pafd_sink and the bound checker are compiled first.
module picture_adjust_field_decimation_tb_top
	import pafd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic wb_ack_o, inValid = 1'b0, inReady, fieldOdd = 1'b0, lineLocked = 1'b1;
	logic outValid, outReady, odd, keep;
	logic [1:0] mode = 2'h0;
	pafd_pixel_t inPixel = '0, outPixel, px;
	pafd_pixel_t expQ[$];
	int seed = 43422, errorCnt = 0, checks = 0, cycles = 0, cnt, n;
	logic [7:0] gain = 8'h80, offs = 8'h00, fy = 8'h10, fc = 8'h88, d, rd;
	logic [7:0] hueSet = 8'h00, chromaGain = 8'h80;
	logic [7:0] resv[8] = '{8'h80, 8'h80, 8'h00, 8'h00, 8'h10, 8'h88, 8'h00, 8'h00};
	logic [31:0] adj[3] = '{32'hff80_80ff, 32'h8010_8000, 32'h4005_0080};
	pafd_top uut (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .inValid, .inReady, .inPixel, .fieldOdd, .lineLocked, .outValid,
		.outReady, .outPixel);
	pafd_sink uSink (.clk, .rst, .outValid, .outReady, .outPixel, .mode);
	initial
		forever #5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			errorCnt++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		$display("checks %0d mismatches %0d", checks, errorCnt);
		if (errorCnt == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : results
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v, input logic s);
		logic seen;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 3'h0, s, 24'h0, v};
		do
		begin
			@(negedge clk);
			seen = wb_ack_o;
			@(posedge clk);
		end
		while (!seen);
		rd = wb_dat_o[7:0];
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge clk);
	endtask : bus
	function automatic logic [7:0] centre(input int c);
		return 8'(((c < -128) ? -128 : (c > 127) ? 127 : c) + 128);
	endfunction : centre
	function automatic pafd_pixel_t expPix(input pafd_pixel_t p);
		int t, u, v;
		t = int'(p.y) * int'(gain) / 128 + int'($signed(offs));
		u = int'(p.cb) - 128;
		v = int'(p.cr) - 128;
		// A hue of 0x80 turns the colour vector by minus ninety degrees.
		if (hueSet[7])
			{u, v} = {v, -u};
		p.y = (t < 0) ? 8'h00 : (t > 255) ? 8'hff : 8'(t);
		p.cb = centre((u * int'(chromaGain)) >>> 7);
		p.cr = centre((v * int'(chromaGain)) >>> 7);
		if (fy[0] || (fy[1] && !lineLocked))
			p = {fy[7:2], 2'b00, fc[3:0], 4'h0, fc[7:4], 4'h0};
		return p;
	endfunction : expPix
	// Sends random pixels back to back; inValid stays high until the caller idles.
	task automatic stream(input int k, input logic o, input logic k2);
		logic seen;
		repeat (k)
		begin
			px = pafd_pixel_t'(24'($random(seed)));
			{inValid, inPixel, fieldOdd} <= {1'b1, px, o};
			do
			begin
				@(negedge clk);
				seen = inReady;
				@(posedge clk);
			end
			while (!seen);
			if (k2)
				expQ.push_back(expPix(px));
		end
	endtask : stream
	task automatic drain();
		inValid <= 1'b0;
		for (int i = 0; i < 3000 && uSink.got.size() < expQ.size(); i++)
			@(posedge clk);
		repeat (20) @(posedge clk);
		check(uSink.got.size(), expQ.size());
		foreach (expQ[i])
			check(32'(uSink.got[i]), 32'(expQ[i]));
		expQ.delete();
		uSink.got.delete();
	endtask : drain
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			errorCnt++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 8; i++)
		begin
			bus(1'b0, 8'(32 + 4 * i), 8'h00, 1'b1);
			check(rd, resv[i]);
			d = $random(seed);
			bus(1'b1, 8'(32 + 4 * i), d, 1'b1);
			bus(1'b1, 8'(32 + 4 * i), ~d, 1'b0);
			bus(1'b0, 8'(32 + 4 * i), 8'h00, 1'b1);
			check(rd, (i == 7) ? 8'h00 : (i == 6) ? {1'b0, d[6:0]} : d);
			bus(1'b1, 8'(32 + 4 * i), resv[i], 1'b1);
		end
		mode <= 2'h1;
		foreach (adj[i])
		begin
			{gain, offs, hueSet, chromaGain} = adj[i];
			bus(1'b1, 8'h20, gain, 1'b1);
			bus(1'b1, 8'h28, offs, 1'b1);
			bus(1'b1, 8'h2c, hueSet, 1'b1);
			bus(1'b1, 8'h24, chromaGain, 1'b1);
			stream(12, fieldOdd, 1'b1);
			drain();
		end
		{gain, offs, fc} = 24'h800088;
		bus(1'b1, 8'h20, gain, 1'b1);
		bus(1'b1, 8'h28, offs, 1'b1);
		fc = 8'h5c;
		bus(1'b1, 8'h34, fc, 1'b1);
		for (int i = 0; i < 4; i++)
		begin
			fy = {6'h2a, 2'(i == 0 ? 1 : i < 3 ? 2 : 0)};
			lineLocked <= (i == 0 || i == 2);
			bus(1'b1, 8'h30, fy, 1'b1);
			bus(1'b0, 8'h48, 8'h00, 1'b1);
			check(rd, {4'h0, fieldOdd, lineLocked, 1'b0, fy[0] | (fy[1] & !lineLocked)});
			stream(6, fieldOdd, 1'b1);
			drain();
		end
		fy = 8'h10;
		bus(1'b1, 8'h30, fy, 1'b1);
		mode <= 2'h2;
		repeat (2) @(posedge clk);
		stream(17, fieldOdd, 1'b1);
		inValid <= 1'b0;
		@(negedge clk);
		check(inReady, 1'b0);
		@(posedge clk);
		mode <= 2'h1;
		drain();
		for (int p = 0; p < 4; p++)
		begin
			n = (p == 3) ? 15 : p;
			bus(1'b1, 8'h38, {1'b0, 4'(n), 2'(p), 1'b1}, 1'b1);
			{keep, cnt, odd} = {1'b1, 32'd0, fieldOdd};
			for (int f = 0; f < 40; f++)
			begin
				odd = !odd;
				if (odd == p[0])
					{keep, cnt} = (cnt < n) ? {1'b0, cnt + 1} : {1'b1, 32'd0};
				else if (p[1])
					keep = 1'b1;
				stream(2, odd, keep);
			end
			drain();
		end
		results();
	end
endmodule : picture_adjust_field_decimation_tb_top
